/* File: hw/adr_defines.svh */
// timing counts, address prefix and bit positions for the converter serial target
// assumes the 200 MHz core clock for the filter stages and a 48 ns link clock for the ready counts
`ifndef ADR_DEFINES_SVH
`define ADR_DEFINES_SVH
`define ADR_CLK_PERIOD_NS 5
`define ADR_SCL_MAX_KHZ 1000
`define ADR_ADDR_PREFIX 3'b011
`define ADR_BYTE_BITS 4'h8
`define ADR_RDY_HIGH_MCLK 3'h4
`define ADR_CONT_SKIP 3'h4
`define ADR_CMD_MARK_BIT 7
`define ADR_CMD_REG_BIT 6
`define ADR_NUM_CH 6
`endif

/* File: hw/adr_pkg.sv */
// types shared by the converter serial target
// assumes adr_defines.svh provides the numeric constants
package adr_pkg;
	// sequencer modes 1 to 4
	typedef enum logic [1:0] {ADR_SEQ1, ADR_SEQ2, ADR_SEQ3, ADR_SEQ4} adr_seq_t;
	// conversion events seen on the master clock
	typedef struct packed {
		logic conv_busy;     // modulator converting
		logic ch_update;     // a channel is about to update its data register
		logic last_ch;       // that channel is the last enabled one
		logic [2:0] ch_idx;  // channel being updated
		logic continuous;    // continuous conversion mode
		logic fifo_read_all; // fifo read completely
		logic fifo_irq;      // any fifo usage interrupt active
	} adr_conv_t;
	// first command byte handed to the core
	typedef struct packed {
		logic valid;
		logic [7:0] cmd;
		logic is_reg;
	} adr_cmd_t;
endpackage : adr_pkg

/* File: hw/adr_i2c_ready.sv */
// serial target front end and ready output of a six channel sigma-delta converter
// assumes sda/scl sampled through core clock synchronisers, and the master clock domain
`timescale 1ns/1ps
`include "adr_defines.svh"
module adr_i2c_ready #(
	parameter int NUM_CH = `ADR_NUM_CH
) (
	// core clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// converter master clock domain
	input wire logic mclk_i,
	// serial bus pins, open drain
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// address select straps, four low address bits
	input wire logic [3:0] addr_sel_i,
	// read data source for register reads
	input wire logic [7:0] rd_data_i,
	output logic rd_next_o,
	// command byte out
	output adr_pkg::adr_cmd_t cmd_o,
	// converter status, master clock domain
	input wire adr_pkg::adr_conv_t conv_i,
	input wire adr_pkg::adr_seq_t seq_mode_i,
	input wire logic multichannel_ready_merge,
	input wire logic [NUM_CH-1:0] ch_read_i,
	input wire logic status_clr_i,
	output logic ready_irq_n,
	output logic [NUM_CH-1:0] channel_done_flags,
	output logic modulator_active_flag
);
	import adr_pkg::*;

	// six channels by default; the three bit channel index caps the flag array at eight
	if (NUM_CH < 1 || NUM_CH > 8) begin : g_num_ch_check
		$error("NUM_CH out of range");
	end

	// ---------------- core clock: serial bus ----------------
	// three stage synchronisers; stage one feeds only stage two
	logic [2:0] scl_sy_q;
	logic [2:0] sda_sy_q;
	logic scl_f_q; // filtered clock level
	logic sda_f_q; // filtered data level
	// synchronise and filter, change counts when stages two and three agree
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			scl_sy_q <= 3'h7;
			sda_sy_q <= 3'h7;
			scl_f_q <= 1'b1;
			sda_f_q <= 1'b1;
		end else begin
			scl_sy_q <= {scl_sy_q[1:0], scl_i};
			sda_sy_q <= {sda_sy_q[1:0], sda_i};
			if (scl_sy_q[1] == scl_sy_q[2]) scl_f_q <= scl_sy_q[2];
			if (sda_sy_q[1] == sda_sy_q[2]) sda_f_q <= sda_sy_q[2];
		end
	end
	// edge and condition decode; filter delay of 4 cycles is far below a 1 MHz half period
	logic scl_d1_q;
	logic sda_d1_q;
	wire scl_rise = scl_f_q & ~scl_d1_q;
	wire scl_fall = ~scl_f_q & scl_d1_q;
	wire start_det = scl_f_q & scl_d1_q & sda_d1_q & ~sda_f_q;
	wire stop_det = scl_f_q & scl_d1_q & ~sda_d1_q & sda_f_q;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			scl_d1_q <= 1'b1;
			sda_d1_q <= 1'b1;
		end else begin
			scl_d1_q <= scl_f_q;
			sda_d1_q <= sda_f_q;
		end
	end

	// bus state machine
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK, ST_WDATA,
		ST_RDATA, ST_RACK} adr_bus_st_t;
	adr_bus_st_t st_q;
	adr_bus_st_t st_d;
	logic [3:0] bit_q; // bits taken in this byte
	logic [7:0] sh_q; // shift register, msb first
	logic first_q; // next address byte is the first of the transaction
	logic got_cmd_q; // command byte already seen
	logic drv_low_q; // pull data low
	logic [7:0] cmd_q;
	logic cmd_v_q;
	logic rd_next_q;
	// address match: prefix plus straps, rejects general call by construction
	wire [6:0] my_addr = {`ADR_ADDR_PREFIX, addr_sel_i};
	wire addr_hit = (sh_q[7:1] == my_addr);
	wire byte_done = (bit_q == `ADR_BYTE_BITS);
	// first byte must be a write; a read there is ignored (no ack)
	wire addr_ok = addr_hit & (first_q ? ~sh_q[0] : 1'b1);
	wire cmd_ok = sh_q[`ADR_CMD_MARK_BIT];
	wire rx_state = (st_q == ST_ADDR) || (st_q == ST_CMD) || (st_q == ST_WDATA);

	// next state on falling edge after eighth bit or ack
	always_comb begin
		st_d = st_q;
		if (scl_fall) begin
			unique case (st_q)
				ST_IDLE: st_d = ST_IDLE;
				ST_ADDR: if (byte_done) st_d = addr_ok ? ST_ADDR_ACK : ST_IDLE;
				ST_ADDR_ACK: st_d = sh_q[0] ? ST_RDATA : (got_cmd_q ? ST_WDATA : ST_CMD);
				ST_CMD: if (byte_done) st_d = cmd_ok ? ST_CMD_ACK : ST_IDLE;
				ST_CMD_ACK: st_d = ST_WDATA;
				ST_WDATA: if (byte_done) st_d = ST_CMD_ACK;
				ST_RDATA: if (byte_done) st_d = ST_RACK;
				ST_RACK: st_d = ST_RACK;
			endcase
		end
	end

	// shifting, acks and driving; starts and stops override everything
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_q <= ST_IDLE;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			first_q <= 1'b1;
			got_cmd_q <= 1'b0;
			drv_low_q <= 1'b0;
			cmd_q <= 8'h00;
			cmd_v_q <= 1'b0;
			rd_next_q <= 1'b0;
		end else begin
			cmd_v_q <= 1'b0;
			rd_next_q <= 1'b0;
			if (start_det) begin
				// repeated start keeps the command seen so far
				first_q <= (st_q == ST_IDLE) | ~got_cmd_q;
				st_q <= ST_ADDR;
				bit_q <= 4'h0;
				drv_low_q <= 1'b0;
			end else if (stop_det) begin
				st_q <= ST_IDLE;
				first_q <= 1'b1;
				got_cmd_q <= 1'b0;
				drv_low_q <= 1'b0;
			end else begin
				if (scl_rise && rx_state && !byte_done) begin
					sh_q <= {sh_q[6:0], sda_f_q};
					bit_q <= bit_q + 4'h1;
				end
				if (scl_rise && st_q == ST_RACK && sda_f_q) begin
					st_q <= ST_IDLE;
				end else if (scl_rise && st_q == ST_RDATA && !byte_done) begin
					bit_q <= bit_q + 4'h1;
				end else if (scl_fall) begin
					st_q <= st_d;
					unique case (st_q)
						ST_ADDR, ST_CMD, ST_WDATA: begin
							// ack driven from this fall to the next
							drv_low_q <= byte_done && (st_d != ST_IDLE);
							if (st_q == ST_CMD && byte_done && cmd_ok) begin
								cmd_q <= sh_q;
								cmd_v_q <= 1'b1;
								got_cmd_q <= 1'b1;
							end
						end
						ST_ADDR_ACK: begin
							first_q <= 1'b0;
							bit_q <= 4'h0;
							sh_q <= rd_data_i;
							drv_low_q <= sh_q[0] & ~rd_data_i[7];
						end
						ST_CMD_ACK: begin
							bit_q <= 4'h0;
							drv_low_q <= 1'b0;
						end
						ST_RDATA: begin
							if (byte_done) begin
								drv_low_q <= 1'b0; // release for master ack
								rd_next_q <= 1'b1;
							end else begin
								sh_q <= {sh_q[6:0], 1'b0};
								drv_low_q <= ~sh_q[6];
							end
						end
						ST_RACK: begin
							bit_q <= 4'h0;
							sh_q <= rd_data_i;
							st_q <= ST_RDATA;
							drv_low_q <= ~rd_data_i[7];
						end
						default: drv_low_q <= 1'b0;
					endcase
				end
			end
		end
	end

	// open drain outputs: data low only, clock never driven
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sda_oe_o <= 1'b0;
			sda_o <= 1'b0;
			scl_oe_o <= 1'b0;
			scl_o <= 1'b0;
			cmd_o <= '0;
			rd_next_o <= 1'b0;
		end else begin
			sda_oe_o <= drv_low_q;
			sda_o <= 1'b0;
			scl_oe_o <= 1'b0;
			scl_o <= 1'b0;
			cmd_o <= '{valid: cmd_v_q, cmd: cmd_q, is_reg: cmd_q[`ADR_CMD_REG_BIT]};
			rd_next_o <= rd_next_q;
		end
	end

	// ---------------- master clock: ready output ----------------
	// reset is released into the master domain through two flops
	logic [1:0] mrst_q;
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) mrst_q <= 2'b00;
		else mrst_q <= {mrst_q[0], 1'b1};
	end
	wire mrst_n = mrst_q[1];

	// an update is announced early; ready goes high, then falls four cycles later
	logic [2:0] hi_cnt_q; // cycles of forced high before the fall
	logic rdy_lo_q; // result pending, ready low
	logic [2:0] skip_q; // continuous results still to skip
	logic [NUM_CH-1:0] pend_q; // channel with unread data
	logic [2:0] upd_ch_q;
	logic upd_fall_q; // this update will make ready fall
	wire multi = (seq_mode_i == ADR_SEQ2) || (seq_mode_i == ADR_SEQ3);
	wire data_mode = (seq_mode_i != ADR_SEQ4);
	// merged mode lets only the last channel fall
	wire want_fall = ~(multi & multichannel_ready_merge) | conv_i.last_ch;
	wire skip_now = conv_i.continuous & (skip_q != 3'h0);
	wire read_clr = conv_i.fifo_read_all | (multi & ~multichannel_ready_merge &
		|(ch_read_i & pend_q));
	wire fall_now = (hi_cnt_q == 3'h1) & upd_fall_q;
	always_ff @(posedge mclk_i or negedge mrst_n) begin
		if (!mrst_n) begin
			hi_cnt_q <= 3'h0;
			rdy_lo_q <= 1'b0;
			skip_q <= `ADR_CONT_SKIP;
			pend_q <= '0;
			upd_ch_q <= 3'h0;
			upd_fall_q <= 1'b0;
		end else begin
			if (!conv_i.continuous) skip_q <= `ADR_CONT_SKIP;
			if (conv_i.ch_update && data_mode) begin
				// high four cycles before the register update, unread or not
				hi_cnt_q <= `ADR_RDY_HIGH_MCLK;
				rdy_lo_q <= 1'b0;
				upd_ch_q <= conv_i.ch_idx;
				upd_fall_q <= want_fall & ~skip_now;
				if (skip_now) skip_q <= skip_q - 3'h1;
			end else if (hi_cnt_q != 3'h0) begin
				hi_cnt_q <= hi_cnt_q - 3'h1;
				if (fall_now) begin
					rdy_lo_q <= 1'b1;
					pend_q[upd_ch_q] <= 1'b1;
				end
			end else if (read_clr) begin
				rdy_lo_q <= 1'b0;
				pend_q <= '0;
			end
		end
	end

	// status flags; a finish in the clear cycle wins
	logic [NUM_CH-1:0] done_q;
	wire [NUM_CH-1:0] done_set = (conv_i.ch_update && seq_mode_i != ADR_SEQ1) ?
		(NUM_CH'(1) << conv_i.ch_idx) : '0;
	always_ff @(posedge mclk_i or negedge mrst_n) begin
		if (!mrst_n) begin
			done_q <= '0;
			ready_irq_n <= 1'b1;
			channel_done_flags <= '0;
			modulator_active_flag <= 1'b0;
		end else begin
			done_q <= (status_clr_i ? '0 : done_q) | done_set;
			channel_done_flags <= (status_clr_i ? '0 : done_q) | done_set;
			modulator_active_flag <= conv_i.conv_busy;
			// fifo interrupts pull ready low in data modes; mode four uses them alone
			ready_irq_n <= ~((data_mode & rdy_lo_q & (hi_cnt_q == 3'h0)) |
				conv_i.fifo_irq);
		end
	end

	// assertions
	AST_SCL_NEVER: assert property (@(posedge clk_i) disable iff (!reset_n_i) !scl_oe_o)
		else $error("serial clock driven");
	AST_OD: assert property (@(posedge clk_i) disable iff (!reset_n_i) sda_oe_o |-> !sda_o)
		else $error("data driven high");
	AST_SDA_CHG: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		$rose(drv_low_q) |-> $past(scl_fall))
		else $error("data pulled off a falling edge");
	AST_STOP_IDLE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		stop_det |=> st_q == ST_IDLE)
		else $error("stop not honoured");
	AST_START: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		start_det |=> st_q == ST_ADDR && bit_q == 4'h0)
		else $error("start not honoured");
	AST_NACK: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(st_q == ST_RACK && scl_rise && sda_f_q && !start_det && !stop_det) |=> st_q == ST_IDLE)
		else $error("nack did not reset");
	AST_BAD_ADDR: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(st_q == ST_ADDR && byte_done && scl_fall && !addr_ok && !start_det && !stop_det)
		|=> !drv_low_q)
		else $error("foreign address acknowledged");
	AST_HIGH4: assert property (@(posedge mclk_i) disable iff (!mrst_n)
		(conv_i.ch_update && data_mode) |=> hi_cnt_q == `ADR_RDY_HIGH_MCLK ##1 !rdy_lo_q)
		else $error("ready not held high before update");
	AST_MOD: assert property (@(posedge mclk_i) disable iff (!mrst_n)
		modulator_active_flag == $past(conv_i.conv_busy))
		else $error("modulator flag lags");
endmodule : adr_i2c_ready

/* File: verification/adr_host_model.sv */
// host bus master model: start, stop and byte transfers on open-drain lines
// assumes the bench resolves both lines with pull-ups and feeds the data level back
`timescale 1ns/1ps
module adr_host_model #(
	parameter int HALF = 100
) (
	// core clock paces the bus, half of a 1 MHz bit is 100 cycles
	input wire logic clk_i,
	// resolved data line
	input wire logic sda_i,
	// pull-down enables, high pulls the line low
	output logic scl_oe_o,
	output logic sda_oe_o
);
	// both lines released while idle
	initial begin
		scl_oe_o = 1'b0;
		sda_oe_o = 1'b0;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge clk_i);
	endtask : hold

	// start or repeated start: data falls while the clock is high
	task automatic start_c();
		sda_oe_o <= 1'b0;
		hold(HALF / 2);
		scl_oe_o <= 1'b0;
		hold(HALF / 2);
		sda_oe_o <= 1'b1;
		hold(HALF / 2);
		scl_oe_o <= 1'b1;
		hold(HALF / 2);
	endtask : start_c

	// stop: data rises while the clock is high
	task automatic stop_c();
		sda_oe_o <= 1'b1;
		hold(HALF / 2);
		scl_oe_o <= 1'b0;
		hold(HALF / 2);
		sda_oe_o <= 1'b0;
		hold(HALF / 2);
	endtask : stop_c

	// one bit at 1 MHz; data moves only while the clock is low
	task automatic bit_x(input logic b, output logic r);
		sda_oe_o <= ~b;
		hold(HALF / 2);
		scl_oe_o <= 1'b0;
		hold(HALF / 2);
		r = sda_i;
		hold(HALF / 2);
		scl_oe_o <= 1'b1;
		hold(HALF / 2);
	endtask : bit_x

	// eight bits msb first, then the acknowledge slot; send ff to read
	task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
			output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], q[i]);
		end
		bit_x(ack_in, ack);
	endtask : xfer
endmodule : adr_host_model

/* File: verification/tb_adc_i2c_slave_ready_logic.sv */
// self-checking bench for the serial target and ready output
// assumes adr_host_model as the bus master and 200 MHz / 48 ns clocks
`timescale 1ns/1ps
`include "adr_defines.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
	$display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_adc_i2c_slave_ready_logic;
	import adr_pkg::*;
	logic clk_i, reset_n_i, mclk_i, scl_o, scl_oe_o, sda_o, sda_oe_o, m_scl_oe, m_sda_oe;
	logic rd_next_o, ack, merge, status_clr_i, ready_irq_n, modulator_active_flag;
	logic [7:0] rd_data_i, q;
	logic [5:0] ch_read_i, channel_done_flags;
	logic [3:0] addr_sel_i;
	adr_cmd_t cmd_o, last_cmd;
	adr_conv_t conv_i;
	adr_seq_t seq_mode_i;
	int fail_count = 0;
	int total_checks = 0;
	int rd_cnt = 0;
	// wired-and lines with pull-ups
	wire scl = ~(m_scl_oe | scl_oe_o);
	wire sda = ~(m_sda_oe | sda_oe_o);
	localparam logic [7:0] ADDR_W = {`ADR_ADDR_PREFIX, 4'h5, 1'b0};

	adr_i2c_ready i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .mclk_i(mclk_i),
		.scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda), .sda_o(sda_o),
		.sda_oe_o(sda_oe_o), .addr_sel_i(addr_sel_i), .rd_data_i(rd_data_i),
		.rd_next_o(rd_next_o), .cmd_o(cmd_o), .conv_i(conv_i), .seq_mode_i(seq_mode_i),
		.multichannel_ready_merge(merge), .ch_read_i(ch_read_i),
		.status_clr_i(status_clr_i), .ready_irq_n(ready_irq_n),
		.channel_done_flags(channel_done_flags),
		.modulator_active_flag(modulator_active_flag));
	adr_host_model i_host (.clk_i(clk_i), .sda_i(sda), .scl_oe_o(m_scl_oe),
		.sda_oe_o(m_sda_oe));

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	// link clock, phase unrelated to the core clock
	initial begin
		mclk_i = 1'b0;
		#7;
		forever #24 mclk_i = ~mclk_i;
	end
	// remember the last command and step the read data after each byte
	always @(posedge clk_i) if (cmd_o.valid === 1'b1) last_cmd <= cmd_o;
	always @(posedge clk_i) if (rd_next_o === 1'b1) rd_cnt <= rd_cnt + 1;
	assign rd_data_i = 8'hA5 ^ {rd_cnt[3:0], 4'h0};
	// the device may move data only with the clock low, and never the clock
	always @(sda_oe_o or scl_oe_o) if (reset_n_i === 1'b1) begin
		`CHK(scl_oe_o, 1'b0)
		`CHK(scl_o, 1'b0)
		`CHK(sda_o, 1'b0)
		`CHK(scl, 1'b0)
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_sim

	task automatic wr(input logic [7:0] d, input logic exp_ack);
		i_host.xfer(d, 1'b1, q, ack);
		`CHK(ack, exp_ack)
	endtask : wr

	task automatic rd(input logic [7:0] exp_q, input logic nack);
		i_host.xfer(8'hFF, nack, q, ack);
		`CHK(q, exp_q)
	endtask : rd

	// one-edge channel update notice on the master clock
	task automatic upd(input logic [2:0] ch, input logic last);
		conv_i.ch_update <= 1'b1;
		conv_i.ch_idx <= ch;
		conv_i.last_ch <= last;
		@(posedge mclk_i);
		conv_i.ch_update <= 1'b0;
	endtask : upd

	// bounded wait for a ready level; running out ends the run
	task automatic wait_rdy(input logic v);
		int n;
		for (n = 0; n < 20 && ready_irq_n !== v; n++) @(posedge mclk_i);
		`CHK(ready_irq_n, v)
		if (ready_irq_n !== v) end_sim();
	endtask : wait_rdy

	task automatic idle_mclk(input int n, input logic v);
		repeat (n) @(posedge mclk_i);
		`CHK(ready_irq_n, v)
	endtask : idle_mclk

	initial begin
		reset_n_i = 1'b0;
		conv_i = '0;
		seq_mode_i = ADR_SEQ1;
		merge = 1'b0;
		ch_read_i = 6'h00;
		addr_sel_i = 4'h5;
		status_clr_i = 1'b0;
		repeat (16) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		`CHK(ready_irq_n, 1'b1)
		`CHK(sda_oe_o, 1'b0)
		// register write: address, command, data
		i_host.start_c();
		wr(ADDR_W, 1'b0);
		wr(8'hC5, 1'b0);
		`CHK(last_cmd, {1'b1, 8'hC5, 1'b1})
		wr(8'h3C, 1'b0);
		i_host.stop_c();
		// conversion command
		i_host.start_c();
		wr(ADDR_W, 1'b0);
		wr(8'h95, 1'b0);
		`CHK(last_cmd, {1'b1, 8'h95, 1'b0})
		i_host.stop_c();
		// refusals: other address, general call, read bit in first byte
		foreach (q[i]) if (i < 3) begin
			i_host.start_c();
			wr(i == 0 ? 8'h6C : (i == 1 ? 8'h00 : ADDR_W | 8'h01), 1'b1);
			i_host.stop_c();
		end
		i_host.start_c();
		wr(ADDR_W, 1'b0);
		wr(8'h45, 1'b1);
		i_host.stop_c();
		`CHK(last_cmd, {1'b1, 8'h95, 1'b0})
		// other strap setting moves the address; the old one is then foreign
		addr_sel_i <= 4'hA;
		i_host.start_c();
		wr(ADDR_W, 1'b1);
		i_host.stop_c();
		i_host.start_c();
		wr({`ADR_ADDR_PREFIX, 4'hA, 1'b0}, 1'b0);
		wr(ADDR_W, 1'b1);
		i_host.stop_c();
		addr_sel_i <= 4'h5;
		// register read, two bytes, master nack, then silence until start
		i_host.start_c();
		wr(ADDR_W, 1'b0);
		wr(8'hC1, 1'b0);
		i_host.start_c();
		wr(ADDR_W | 8'h01, 1'b0);
		rd(8'hA5, 1'b0);
		rd(8'hB5, 1'b1);
		wr(8'hFF, 1'b1);
		`CHK(q, 8'hFF)
		i_host.stop_c();
		// single channel ready: four cycles high, low, fifo read returns high
		@(posedge mclk_i);
		upd(3'h0, 1'b1);
		idle_mclk(2, 1'b1);
		wait_rdy(1'b0);
		upd(3'h0, 1'b1);
		wait_rdy(1'b1);
		wait_rdy(1'b0);
		conv_i.fifo_read_all <= 1'b1;
		@(posedge mclk_i);
		conv_i.fifo_read_all <= 1'b0;
		wait_rdy(1'b1);
		// continuous: first four results hidden, fifth falls
		conv_i.continuous <= 1'b1;
		repeat (4) begin
			upd(3'h0, 1'b1);
			idle_mclk(8, 1'b1);
		end
		upd(3'h0, 1'b1);
		wait_rdy(1'b0);
		conv_i.continuous <= 1'b0;
		conv_i.fifo_read_all <= 1'b1;
		@(posedge mclk_i);
		conv_i.fifo_read_all <= 1'b0;
		wait_rdy(1'b1);
		// unmerged multichannel: fall per channel, channel read releases
		seq_mode_i <= ADR_SEQ2;
		status_clr_i <= 1'b1;
		@(posedge mclk_i);
		status_clr_i <= 1'b0;
		upd(3'h2, 1'b0);
		wait_rdy(1'b0);
		`CHK(channel_done_flags, 6'h04)
		ch_read_i <= 6'h04;
		@(posedge mclk_i);
		ch_read_i <= 6'h00;
		wait_rdy(1'b1);
		// merged: only the last channel falls
		seq_mode_i <= ADR_SEQ3;
		merge <= 1'b1;
		upd(3'h0, 1'b0);
		idle_mclk(8, 1'b1);
		upd(3'h1, 1'b1);
		wait_rdy(1'b0);
		`CHK(channel_done_flags, 6'h07)
		conv_i.fifo_read_all <= 1'b1;
		@(posedge mclk_i);
		conv_i.fifo_read_all <= 1'b0;
		wait_rdy(1'b1);
		// fifo interrupt drives ready low; mode four is interrupt only
		conv_i.fifo_irq <= 1'b1;
		wait_rdy(1'b0);
		conv_i.fifo_irq <= 1'b0;
		wait_rdy(1'b1);
		seq_mode_i <= ADR_SEQ4;
		upd(3'h3, 1'b1);
		idle_mclk(8, 1'b1);
		`CHK(channel_done_flags, 6'h0F)
		conv_i.fifo_irq <= 1'b1;
		wait_rdy(1'b0);
		conv_i.fifo_irq <= 1'b0;
		// modulator activity follows conversion; a clear empties the done flags
		conv_i.conv_busy <= 1'b1;
		status_clr_i <= 1'b1;
		@(posedge mclk_i);
		status_clr_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		`CHK(channel_done_flags, 6'h00)
		`CHK(modulator_active_flag, 1'b1)
		conv_i.conv_busy <= 1'b0;
		repeat (3) @(posedge mclk_i);
		`CHK(modulator_active_flag, 1'b0)
		end_sim();
	end
endmodule : tb_adc_i2c_slave_ready_logic
